/* rrnc_set_all_ones_op_core.sv */
// Execution block for rotate-right-no-carry and set-all-ones with APB registers
`timescale 1ns/1ps
`include "rrnc_set_all_ones_op_params.svh"

module rrnc_set_all_ones_op_core
  import rrnc_set_all_ones_op_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Data memory port
  output logic [11:0] dmem_addr_o,
  output logic dmem_we_o,
  output logic [7:0] dmem_wdata_o,
  input wire logic [7:0] dmem_rdata_i,
  // Execution state
  output logic busy_o
);

  // Decoded instruction fields
  decode_if dif ();
  phase_e phase;

  // Architectural state
  logic [15:0] instr_ff;
  logic [15:0] nxt_instr;
  logic [7:0] wreg_ff;
  logic [7:0] nxt_wreg;
  logic [3:0] bank_select_register_ff;
  logic [3:0] nxt_bank_select_register;
  logic carry_ff;
  logic nxt_carry;
  logic zero_ff;
  logic nxt_zero;
  logic neg_ff;
  logic nxt_neg;
  logic illegal_ff;
  logic nxt_illegal;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;

  // Datapath state held across phases
  logic [11:0] addr_ff;
  logic [11:0] nxt_addr;
  logic [7:0] data_ff;
  logic [7:0] nxt_data;
  logic [7:0] result_ff;
  logic [7:0] nxt_result;
  logic we_ff;
  logic nxt_we;

  // Bus state
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // Bus decode
  logic setup;
  logic access;
  logic mapped;
  logic refused;
  logic wr_ok;
  logic wr_instr;
  logic wr_wreg;
  logic wr_bank;
  logic wr_status;
  logic wr_exec;
  logic busy;
  // One select per register, from the bus address
  logic sel_instr;
  logic sel_wreg;
  logic sel_bank;
  logic sel_status;
  logic sel_exec;

  // Phase sequencer and decoder
  q_phase_seq u_seq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(wr_instr),
    .phase_o(phase)
  );

  instr_decoder u_dec (
    .dif(dif)
  );

  assign dif.instr = instr_ff;
  assign busy = (phase != PH_IDLE);

  // Register selects, shared by the map check and the write strobes
  always_comb begin
    sel_instr = (paddr_i == `OFS_INSTR);
    sel_wreg = (paddr_i == `OFS_WREG);
    sel_bank = (paddr_i == `OFS_BANK);
    sel_status = (paddr_i == `OFS_STATUS);
    sel_exec = (paddr_i == `OFS_EXEC);
  end

  // APB phase decode; all writes refused while an instruction runs
  always_comb begin
    setup = psel_i & ~penable_i;
    access = psel_i & penable_i;
    mapped = sel_instr | sel_wreg | sel_bank | sel_status | sel_exec;
    refused = ~mapped | (pwrite_i & busy);
    wr_ok = access & pwrite_i & ~refused;
    wr_instr = wr_ok & sel_instr;
    wr_wreg = wr_ok & sel_wreg;
    wr_bank = wr_ok & sel_bank;
    wr_status = wr_ok & sel_status;
    wr_exec = wr_ok & sel_exec;
  end

  // Zero-wait answer; error for unmapped or busy write
  assign pready_o = access;
  assign pslverr_o = access & refused;

  // Read data captured in the setup cycle
  always_comb begin
    nxt_prdata = prdata_ff;
    if (setup && !pwrite_i) begin
      nxt_prdata = 32'h0000_0000;
      unique case (paddr_i)
        `OFS_INSTR: nxt_prdata = {16'h0000, instr_ff};
        `OFS_WREG: nxt_prdata = {24'h00_0000, wreg_ff};
        `OFS_BANK: nxt_prdata = {28'h000_0000, bank_select_register_ff};
        `OFS_STATUS: begin
          nxt_prdata[`ST_CARRY] = carry_ff;
          nxt_prdata[`ST_ZERO] = zero_ff;
          nxt_prdata[`ST_NEG] = neg_ff;
        end
        `OFS_EXEC: begin
          nxt_prdata[`EX_BUSY] = busy;
          nxt_prdata[`EX_ILLEGAL] = illegal_ff;
          nxt_prdata[`EX_COUNT_LSB +: 8] = count_ff;
        end
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata_o = prdata_ff;

  // Datapath: address in Q1, read in Q2, process in Q3, write in Q4
  always_comb begin
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_result = result_ff;
    nxt_we = 1'b0;
    unique case (phase)
      PH_Q1: begin
        // Access bit chooses fixed access bank or banked address
        nxt_addr = data_addr(bank_select_register_ff, dif.use_bank, dif.faddr);
      end
      PH_Q2: begin
        nxt_data = dmem_rdata_i;
      end
      PH_Q3: begin
        if (dif.is_set_all_ones_op) begin
          nxt_result = `SET_VALUE;
          nxt_we = 1'b1;
        end else if (dif.is_rrnc) begin
          nxt_result = rot_right(data_ff);
          nxt_we = dif.dest_f;
        end
      end
      PH_Q4: begin
        nxt_we = 1'b0;
      end
      PH_IDLE: begin
        nxt_we = 1'b0;
      end
      default: begin
        nxt_we = 1'b0; // Unused phase code never writes memory
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      addr_ff <= 12'h000;
      data_ff <= 8'h00;
      result_ff <= 8'h00;
      we_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      result_ff <= nxt_result;
      we_ff <= nxt_we;
    end
  end

  // Memory port driven from flops; strobe only in Q4
  assign dmem_addr_o = addr_ff;
  assign dmem_wdata_o = result_ff;
  assign dmem_we_o = we_ff;
  assign busy_o = busy;

  // Instruction and bank register writes
  always_comb begin
    nxt_instr = instr_ff;
    nxt_bank_select_register = bank_select_register_ff;
    if (wr_instr) begin
      nxt_instr = pwdata_i[15:0];
    end
    if (wr_bank) begin
      nxt_bank_select_register = pwdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      instr_ff <= `RST_INSTR;
      bank_select_register_ff <= `RST_BANK;
    end else begin
      instr_ff <= nxt_instr;
      bank_select_register_ff <= nxt_bank_select_register;
    end
  end

  // Working register and flags; Q4 writeback, bus writes only while idle
  always_comb begin
    nxt_wreg = wreg_ff;
    nxt_carry = carry_ff;
    nxt_zero = zero_ff;
    nxt_neg = neg_ff;
    if (wr_wreg) begin
      nxt_wreg = pwdata_i[7:0];
    end
    if (wr_status) begin
      nxt_carry = pwdata_i[`ST_CARRY];
      nxt_zero = pwdata_i[`ST_ZERO];
      nxt_neg = pwdata_i[`ST_NEG];
    end
    if (phase == PH_Q4 && dif.is_rrnc) begin
      if (!dif.dest_f) begin
        nxt_wreg = result_ff;
      end
      // Carry untouched by the rotate
      nxt_neg = result_ff[7];
      nxt_zero = (result_ff == 8'h00);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wreg_ff <= `RST_WREG;
      carry_ff <= `RST_FLAG;
      zero_ff <= `RST_FLAG;
      neg_ff <= `RST_FLAG;
    end else begin
      wreg_ff <= nxt_wreg;
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
      neg_ff <= nxt_neg;
    end
  end

  // Illegal-opcode flag, write one to clear; set wins over clear
  always_comb begin
    nxt_illegal = illegal_ff;
    nxt_count = count_ff;
    if (wr_exec && pwdata_i[`EX_ILLEGAL]) begin
      nxt_illegal = 1'b0;
    end
    if (phase == PH_Q1 && !dif.is_rrnc && !dif.is_set_all_ones_op) begin
      nxt_illegal = 1'b1;
    end
    if (phase == PH_Q4 && (dif.is_rrnc || dif.is_set_all_ones_op)) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      illegal_ff <= `RST_FLAG;
      count_ff <= 8'h00;
    end else begin
      illegal_ff <= nxt_illegal;
      count_ff <= nxt_count;
    end
  end

endmodule

/* rrnc_set_all_ones_op_params.svh */
// Constants for the rotate-right and set-all-ones execution block
`ifndef RRNC_SET_ALL_ONES_OP_PARAMS_SVH
`define RRNC_SET_ALL_ONES_OP_PARAMS_SVH
// Overview of operation
// - Rotate: byte moves right one place, bit 0 to bit 7, N and Z updated, C kept.
// - Rotate with destination bit 0 writes working register; memory byte untouched.
// - Rotate with destination bit 1 writes result back to the addressed byte.
// - Access bit 0 resolves address in the fixed access bank, bank register ignored.
// - Access bit 1 forms address from bank register and file address.
// - Set-all-ones writes FFh into the addressed byte; no status flag changes.
// - Each takes one word, one cycle: decode, read, process, write phases.

// Register byte offsets
`define OFS_INSTR 12'h000
`define OFS_WREG 12'h004
`define OFS_BANK 12'h008
`define OFS_STATUS 12'h00C
`define OFS_EXEC 12'h010

// Status field positions
`define ST_CARRY 0
`define ST_ZERO 2
`define ST_NEG 4
// Exec field positions
`define EX_BUSY 0
`define EX_ILLEGAL 1
`define EX_COUNT_LSB 8

// Reset values
`define RST_INSTR 16'hFFFF
`define RST_WREG 8'h00
`define RST_BANK 4'h0
`define RST_FLAG 1'b0

// Opcode patterns and field positions
`define OPC_RRNC 6'h10
`define OPC_SET_ALL_ONES_OP 7'h34
`define FLD_DEST 9
`define FLD_ACCESS 8
`define SET_VALUE 8'hFF

// Access bank split and upper bank number
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_BANK 4'hF

// Timing: phases per instruction cycle
`define Q_PHASES 4
`endif

/* rrnc_set_all_ones_op_pkg.sv */
// Types and shared functions for the rotate and set execution block
package rrnc_set_all_ones_op_pkg;
  `include "rrnc_set_all_ones_op_params.svh"

  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;
  typedef logic [11:0] data_addr_t;

  // Data memory address from bank register, access bit and file address
  function automatic data_addr_t data_addr(input logic [3:0] bank, input logic use_bank,
                                           input logic [7:0] faddr);
    data_addr_t a;
    a = {bank, faddr};
    if (!use_bank) begin
      if (faddr < `ACCESS_SPLIT) begin
        a = {4'h0, faddr};
      end else begin
        a = {`ACCESS_HI_BANK, faddr};
      end
    end
    return a;
  endfunction

  // Rotate right one place without carry
  function automatic logic [7:0] rot_right(input logic [7:0] v);
    return {v[0], v[7:1]};
  endfunction
endpackage

/* decode_if.sv */
// Carrier for instruction word and its decoded fields
`timescale 1ns/1ps
interface decode_if;
  logic [15:0] instr;
  logic is_rrnc;
  logic is_set_all_ones_op;
  logic dest_f;
  logic use_bank;
  logic [7:0] faddr;

  modport dec (input instr, output is_rrnc, is_set_all_ones_op, dest_f, use_bank, faddr);
  modport core (output instr, input is_rrnc, is_set_all_ones_op, dest_f, use_bank, faddr);
endinterface

/* instr_decoder.sv */
// Opcode recogniser for rotate-right and set-all-ones
`timescale 1ns/1ps
`include "rrnc_set_all_ones_op_params.svh"

module instr_decoder
  import rrnc_set_all_ones_op_pkg::*;
(
  decode_if.dec dif
);
  // Field split of the instruction word
  always_comb begin
    dif.is_rrnc = (dif.instr[15:10] == `OPC_RRNC);
    dif.is_set_all_ones_op = (dif.instr[15:9] == `OPC_SET_ALL_ONES_OP);
    dif.dest_f = dif.is_rrnc & dif.instr[`FLD_DEST];
    dif.use_bank = dif.instr[`FLD_ACCESS];
    dif.faddr = dif.instr[7:0];
  end
endmodule

/* q_phase_seq.sv */
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
module q_phase_seq
  import rrnc_set_all_ones_op_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic start_i,
  output phase_e phase_o
);
  phase_e phase_ff;
  phase_e nxt_phase;

  // Phase advance, one phase per clock
  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_IDLE: begin
        if (start_i) begin
          nxt_phase = PH_Q1;
        end
      end
      PH_Q1: nxt_phase = PH_Q2;
      PH_Q2: nxt_phase = PH_Q3;
      PH_Q3: nxt_phase = PH_Q4;
      PH_Q4: nxt_phase = PH_IDLE;
      default: nxt_phase = PH_IDLE; // Unused code falls back to idle
    endcase
  end

  // Phase register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phase_ff <= PH_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign phase_o = phase_ff;
endmodule

/* rrnc_set_all_ones_op_checker.sv */
// Port checker for the rotate and set-all-ones block
`timescale 1ns/1ps
`include "rrnc_set_all_ones_op_params.svh"

module rrnc_set_all_ones_op_checker (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // Memory port and state
  input wire logic [11:0] dmem_addr_o,
  input wire logic dmem_we_o,
  input wire logic [7:0] dmem_wdata_o,
  input wire logic [7:0] dmem_rdata_i,
  input wire logic busy_o
);
  logic go, rot, set;
  logic [7:0] fa, rd;
  logic [3:0] bank_seen;
  // Accepted instruction write and its fields
  assign go = psel_i & penable_i & pwrite_i & pready_o & (paddr_i == `OFS_INSTR) & !busy_o;
  assign rot = go & (pwdata_i[15:10] == `OPC_RRNC);
  assign set = go & (pwdata_i[15:9] == `OPC_SET_ALL_ONES_OP);
  // Bank register as last taken by an idle bus write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bank_seen <= `RST_BANK;
    end else if (psel_i && penable_i && pwrite_i && pready_o && !busy_o &&
                 paddr_i == `OFS_BANK) begin
      bank_seen <= pwdata_i[3:0];
    end
  end
  assign fa = pwdata_i[7:0];
  assign rd = {dmem_rdata_i[0], dmem_rdata_i[7:1]};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_busy_len: assert property ($rose(busy_o) |-> busy_o[*4] ##1 !busy_o)
    else $error("busy length wrong");
  chk_we_phase: assert property ($rose(busy_o) |-> !dmem_we_o[*3])
    else $error("write before last phase");
  chk_we_pulse: assert property (dmem_we_o |=> !dmem_we_o)
    else $error("write strobe too long");
  chk_rot_data: assert property (dmem_we_o && dmem_wdata_o != 8'hFF |->
    dmem_wdata_o == $past(rd, 2)) else $error("rotated byte wrong");
  chk_rot_back: assert property (rot && pwdata_i[9] |-> ##4 dmem_we_o)
    else $error("rotate did not write back");
  chk_rot_wreg: assert property (rot && !pwdata_i[9] |-> ##1 !dmem_we_o[*4])
    else $error("rotate to working register wrote memory");
  chk_set_ones: assert property (set |-> ##4 dmem_we_o && dmem_wdata_o == 8'hFF)
    else $error("set did not write all ones");
  chk_access_bank: assert property ((rot || set) && !pwdata_i[8] |-> ##2
    dmem_addr_o == ($past(fa, 2) < `ACCESS_SPLIT ? {4'h0, $past(fa, 2)} :
    {`ACCESS_HI_BANK, $past(fa, 2)}))
    else $error("access bank address wrong");
  chk_bank_field: assert property ((rot || set) && pwdata_i[8] |-> ##2
    dmem_addr_o == {bank_seen, $past(fa, 2)}) else $error("banked address wrong");
endmodule

bind rrnc_set_all_ones_op_core rrnc_set_all_ones_op_checker rrnc_set_all_ones_op_checker_inst (.clk_i, .reset_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .dmem_addr_o, .dmem_we_o,
  .dmem_wdata_o, .dmem_rdata_i, .busy_o);

/* rrnc_set_all_ones_op_core_tb_top.sv */
// Self-checking bench for the rotate and set-all-ones block
`timescale 1ns/1ps
module rrnc_set_all_ones_op_core_tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rdat;
  logic pready_o, pslverr_o, dmem_we_o, busy_o, err;
  logic [11:0] dmem_addr_o;
  logic [7:0] dmem_wdata_o, dmem_rdata_i;
  logic [7:0] mem [0:4095];
  int n_mismatch = 0;
  int comparisons = 0;
  int nwr = 0;
  int k;

  rrnc_set_all_ones_op_core rrnc_set_all_ones_op_core_inst (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .dmem_addr_o, .dmem_we_o,
    .dmem_wdata_o, .dmem_rdata_i, .busy_o);

  // Clock
  always #5 clk_i = ~clk_i;
  // Data memory behind the block
  assign dmem_rdata_i = mem[dmem_addr_o];
  always @(posedge clk_i) begin
    if (dmem_we_o === 1'b1) begin
      mem[dmem_addr_o] <= dmem_wdata_o;
      nwr <= nwr + 1;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    rdat = prdata_o;
    err = pslverr_o;
    if (n >= 16) n_mismatch++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 16) n_mismatch++;
  endtask

  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset();
    apb(1'b0, 12'h000, 32'h0);
    cmp(rdat, 32'h0000FFFF);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rdat, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    cmp({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_rot_mem();
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h00C, 32'h1);
    mem[12'hF95] <= 8'hD7;
    apb(1'b1, 12'h000, {16'h0, 6'h10, 1'b1, 1'b0, 8'h95});
    idle();
    cmp({24'h0, mem[12'hF95]}, 32'hEB);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rdat, 32'h11);
    $display("test rotate to memory done");
  endtask

  task automatic t_rot_w();
    apb(1'b1, 12'h004, 32'h5A);
    mem[12'h045] <= 8'h02;
    k = nwr;
    apb(1'b1, 12'h000, {16'h0, 6'h10, 1'b0, 1'b1, 8'h45});
    idle();
    apb(1'b0, 12'h004, 32'h0);
    cmp(rdat, 32'h0);
    cmp(nwr - k, 0);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rdat, 32'h5);
    $display("test rotate to working register done");
  endtask

  task automatic t_set();
    mem[12'h310] <= 8'h5A;
    apb(1'b1, 12'h000, {16'h0, 7'h34, 1'b1, 8'h10});
    idle();
    cmp({24'h0, mem[12'h310]}, 32'hFF);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rdat, 32'h5);
    $display("test set done");
  endtask

  task automatic t_busy();
    k = nwr;
    mem[12'h020] <= 8'h01;
    apb(1'b1, 12'h000, {16'h0, 6'h10, 1'b1, 1'b0, 8'h20});
    apb(1'b1, 12'h004, 32'hA5);
    cmp({31'h0, err}, 32'h1);
    idle();
    apb(1'b1, 12'h000, 32'h4400);
    idle();
    cmp(nwr - k, 1);
    apb(1'b0, 12'h004, 32'h0);
    cmp(rdat, 32'h0);
    cmp({24'h0, mem[12'h020]}, 32'h80);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rdat, 32'h0000_0402);
    apb(1'b1, 12'h010, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rdat, 32'h0000_0400);
    $display("test busy and opcode done");
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_rot_mem();
    t_rot_w();
    t_set();
    t_busy();
    give_verdict();
  end

  // Watchdog
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
endmodule
